/* File: hdl/ccr_map.svh */
// Purpose: Register offsets, field positions and reset values of the comparator control bank.
// Assumes: Byte-wide registers on a plain address/strobe port.
// Notes: Offsets are the printed addresses; data is 8 bits wide.
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

`define CCR_ADDR_W 12
`define CCR_OFF_CMP0_POL 12'hF91
`define CCR_OFF_CMP1_CTL 12'hF92
`define CCR_OFF_CMP1_POL 12'hF93
`define CCR_OFF_WINDOW 12'hF8F
`define CCR_OFF_CMP0_INSEL 12'hF90
`define CCR_OFF_STATUS 12'hF94
`define CCR_POL_BIT 7
`define CCR_PWR_HI 7
`define CCR_PWR_LO 6
`define CCR_HYS_HI 5
`define CCR_HYS_LO 4
`define CCR_NEG_HI 3
`define CCR_NEG_LO 2
`define CCR_POS_HI 1
`define CCR_POS_LO 0
`define CCR_WIN_BIT 2
`define CCR_PREF_BIT 3
`define CCR_RST_BYTE 8'h00
`define CCR_RST_BIT 1'b0

`endif

/* File: hdl/ccr_pkg.sv */
// Purpose: Types shared by the comparator control bank.
// Assumes: Nothing beyond the map header.
// Notes: Encodings follow the field values of the control register.
package ccr_pkg;

  typedef enum logic [1:0] {
    CCR_PWR_ULTRA_LOW,
    CCR_PWR_LOW,
    CCR_PWR_NORMAL,
    CCR_PWR_HIGH_SPEED
  } ccr_power_t;

  typedef enum logic [1:0] {
    CCR_HYS_NONE,
    CCR_HYS_SMALL,
    CCR_HYS_RESERVED,
    CCR_HYS_LARGE
  } ccr_hysteresis_sel_t;

  // One-hot routing of the negative input: pin a, pin b, bandgap, programmable, fixed.
  typedef logic [4:0] ccr_neg_route_t;

  // One-hot routing of the positive input: pin a, pin b, op amp 1, op amp 0.
  typedef logic [3:0] ccr_pos_route_t;

  typedef struct packed {
    logic cmp0_invert;
    logic cmp1_invert;
    logic [7:0] cmp1_ctl;
    logic window_mode_on;
    logic prog_ref_on;
    logic [1:0] cmp0_pos_sel;
    logic [7:0] rdata;
  } ccr_state_t;

endpackage

/* File: hdl/ccr_regs.sv */
// Purpose: Control registers for two analog comparators and their output polarity logic.
// Assumes: Registers are written and read over a plain strobed port; all inputs are synchronous.
// Notes: Select lines are static levels held by flip-flops and drive the analog front end.
`timescale 1ns/100ps
`include "ccr_map.svh"

module ccr_regs (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [`CCR_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic cmp0_raw_in,
  input wire logic cmp1_raw_in,
  output logic cmp0_result_out,
  output logic cmp1_result_out,
  output logic combined_result_out,
  output logic [1:0] status_out,
  output ccr_pkg::ccr_power_t power_speed_sel_out,
  output ccr_pkg::ccr_hysteresis_sel_t hysteresis_sel_out,
  output ccr_pkg::ccr_neg_route_t neg_route_out,
  output ccr_pkg::ccr_pos_route_t pos_route_out,
  output logic window_mode_on_out
);
  import ccr_pkg::*;

  ccr_state_t st_r;
  ccr_state_t st_nxt;
  logic [1:0] neg_input_sel;
  logic [1:0] pos_input_sel;
  logic [1:0] pos_eff;
  logic c0;
  logic c1;
  logic [1:0] status;

  assign neg_input_sel = st_r.cmp1_ctl[`CCR_NEG_HI:`CCR_NEG_LO];
  assign pos_input_sel = st_r.cmp1_ctl[`CCR_POS_HI:`CCR_POS_LO];

  // Polarity is applied before anything else sees the results.
  assign c0 = cmp0_raw_in ^ st_r.cmp0_invert;
  assign c1 = cmp1_raw_in ^ st_r.cmp1_invert;

  // Status reflects inverted results; window mode reports a joint state.
  always_comb begin
    if (st_r.window_mode_on) begin
      if (c0 != c1) begin
        status = 2'h1;
      end else if (c0) begin
        status = 2'h2;
      end else begin
        status = 2'h0;
      end
    end else begin
      status = {c0, c1};
    end
  end

  // In window mode the comparator 1 positive field is ignored entirely.
  assign pos_eff = st_r.window_mode_on ? st_r.cmp0_pos_sel : pos_input_sel;

  // Register write and read-back path; the read data lives one cycle only.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    if (wr_in) begin
      case (addr_in)
        `CCR_OFF_CMP0_POL: st_nxt.cmp0_invert = wdata_in[`CCR_POL_BIT];
        `CCR_OFF_CMP1_CTL: st_nxt.cmp1_ctl = wdata_in;
        `CCR_OFF_CMP1_POL: st_nxt.cmp1_invert = wdata_in[`CCR_POL_BIT];
        `CCR_OFF_WINDOW: st_nxt.window_mode_on = wdata_in[`CCR_WIN_BIT];
        `CCR_OFF_CMP0_INSEL: begin
          st_nxt.cmp0_pos_sel = wdata_in[`CCR_POS_HI:`CCR_POS_LO];
          st_nxt.prog_ref_on = wdata_in[`CCR_PREF_BIT];
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        `CCR_OFF_CMP0_POL: st_nxt.rdata = {st_r.cmp0_invert, 7'h00};
        `CCR_OFF_CMP1_CTL: st_nxt.rdata = st_r.cmp1_ctl;
        `CCR_OFF_CMP1_POL: st_nxt.rdata = {st_r.cmp1_invert, 7'h00};
        `CCR_OFF_WINDOW: st_nxt.rdata = {5'h00, st_r.window_mode_on, status};
        `CCR_OFF_CMP0_INSEL: st_nxt.rdata = {4'h0, st_r.prog_ref_on, 1'b0, st_r.cmp0_pos_sel};
        `CCR_OFF_STATUS: st_nxt.rdata = {6'h00, c0, c1};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // Synchronous reset returns every control field to its documented zero.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_r.cmp0_invert <= `CCR_RST_BIT;
      st_r.cmp1_invert <= `CCR_RST_BIT;
      st_r.cmp1_ctl <= `CCR_RST_BYTE;
      st_r.window_mode_on <= `CCR_RST_BIT;
      st_r.prog_ref_on <= `CCR_RST_BIT;
      st_r.cmp0_pos_sel <= 2'h0;
      st_r.rdata <= `CCR_RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Negative input routing; the analog side picks the preset level itself.
  always_comb begin
    case (neg_input_sel)
      2'h0: neg_route_out = 5'h01;
      2'h1: neg_route_out = 5'h02;
      2'h2: neg_route_out = st_r.prog_ref_on ? 5'h08 : 5'h04;
      2'h3: neg_route_out = 5'h10;
      default: neg_route_out = 5'h01;
    endcase
  end

  // Positive routing; op amp choices bypass the op amp output pins.
  always_comb begin
    case (pos_eff)
      2'h0: pos_route_out = 4'h1;
      2'h1: pos_route_out = 4'h2;
      2'h2: pos_route_out = 4'h4;
      2'h3: pos_route_out = 4'h8;
      default: pos_route_out = 4'h1;
    endcase
  end

  // Hysteresis code 10 is passed through; software is expected never to write it.
  assign power_speed_sel_out = ccr_power_t'(st_r.cmp1_ctl[`CCR_PWR_HI:`CCR_PWR_LO]);
  assign hysteresis_sel_out = ccr_hysteresis_sel_t'(st_r.cmp1_ctl[`CCR_HYS_HI:`CCR_HYS_LO]);
  assign window_mode_on_out = st_r.window_mode_on;
  assign rdata_out = st_r.rdata;
  assign cmp0_result_out = c0;
  assign cmp1_result_out = c1;
  assign status_out = status;
  // Window mode: combined output high when inside the window.
  assign combined_result_out = st_r.window_mode_on ? (c0 ^ c1) : c0;

endmodule // ccr_regs

/* File: verification/ccr_regs_sva.sv */
// Purpose: Port assertions for the comparator control bank.
// Assumes: One clock; synchronous active-high reset.
// Notes: Most properties tie an output to the write that caused it; pol_read_a checks a read and cfg_hold_a a cycle without a write.
`timescale 1ns/100ps
module ccr_regs_sva (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire ccr_pkg::ccr_power_t power_speed_sel_out,
  input wire ccr_pkg::ccr_neg_route_t neg_route_out,
  input wire ccr_pkg::ccr_pos_route_t pos_route_out,
  input wire logic window_mode_on_out
);
  import ccr_pkg::*;
  // One domain, so clocking and reset qualification are shared.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire w92 = wr_in && addr_in == 12'hF92;
  wire [1:0] n = wdata_in[3:2];
  // A write must land on the very next edge, so a late update fails here.
  pol_read_a: assert property (rd_in && (addr_in == 12'hF91 || addr_in == 12'hF93) |=> !rdata_out[6:0])
    else $error("polarity low bits");
  pwr_set_a: assert property (w92 |=> power_speed_sel_out == $past(wdata_in[7:6]))
    else $error("power field");
  neg_pin_a: assert property (w92 && !n[1] |=> neg_route_out == 5'h01 << $past(n[0]))
    else $error("negative pin");
  neg_ref_a: assert property (w92 && n == 2'h2 |=> neg_route_out inside {5'h04, 5'h08})
    else $error("negative reference");
  neg_fix_a: assert property (w92 && n == 2'h3 |=> neg_route_out == 5'h10)
    else $error("negative fixed");
  pos_sel_a: assert property (w92 && !window_mode_on_out |=> pos_route_out == 4'h1 << $past(wdata_in[1:0]))
    else $error("positive select");
  win_pos_a: assert property (w92 && window_mode_on_out |=> $stable(pos_route_out))
    else $error("window positive");
  cfg_hold_a: assert property (!wr_in |=> $stable(power_speed_sel_out) && $stable(neg_route_out))
    else $error("config hold");
  cover property (w92 && window_mode_on_out);
  cover property (w92 && n == 2'h2);
  cover property (rd_in && addr_in == 12'hF91);
endmodule // ccr_regs_sva
bind ccr_regs ccr_regs_sva chk_u (.*);

/* File: verification/ccr_regs_tb_top.sv */
// Purpose: Self-checking bench for the comparator control bank.
// Assumes: Read data stands one cycle after the read strobe.
// Notes: An integer model predicts every output except window_mode_on_out, and every readback.
`timescale 1ns/100ps
module ccr_regs_tb_top;
  import ccr_pkg::*;
  logic ref_clk_in = 1'h0, rst_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0, cmp0_raw_in = 1'h0, cmp1_raw_in = 1'h0;
  logic [11:0] addr_in = 12'h000;
  logic [7:0] wdata_in = 8'h00, rdata_out;
  logic cmp0_result_out, cmp1_result_out, combined_result_out, window_mode_on_out;
  logic [1:0] status_out;
  ccr_power_t power_speed_sel_out;
  ccr_hysteresis_sel_t hysteresis_sel_out;
  ccr_neg_route_t neg_route_out;
  ccr_pos_route_t pos_route_out;
  int miscompares, checks_done, i0, i1, ctl, win, pref, p0, a, d, r0, r1, n, s;
  int adr[$] = '{12'hF8F, 12'hF90, 12'hF91, 12'hF92, 12'hF93, 12'hF94, 12'hF95};
  ccr_regs dut_u (.*);
  // Clock at 40 MHz.
  always #12.5 ref_clk_in = ~ref_clk_in;
  task automatic chk(input logic [7:0] s, input int x);
    checks_done++;
    if (s !== 8'(x)) begin
      miscompares++;
      $display("Error at %0t: %h vs %h", $time, s, 8'(x));
    end
  endtask
  task automatic conclude();
    $display("%0d checks, %0d mismatches", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Every output but window_mode_on_out and rdata_out is compared, so a stray update of any other field shows.
  task automatic outs();
    r0 = cmp0_raw_in ^ i0;
    r1 = cmp1_raw_in ^ i1;
    n = ctl >> 2 & 3;
    s = win ? (r0 != r1 ? 1 : r0 * 2) : r0 * 2 + r1;
    chk(cmp0_result_out, r0);
    chk(cmp1_result_out, r1);
    chk(status_out, s);
    chk(combined_result_out, win ? r0 ^ r1 : r0);
    chk(power_speed_sel_out, ctl >> 6);
    chk(hysteresis_sel_out, ctl >> 4 & 3);
    chk(neg_route_out, n == 3 ? 16 : n == 2 ? 4 << pref : 1 << n);
    chk(pos_route_out, 1 << (win ? p0 : ctl & 3));
  endtask
  // Reset, then random writes each followed back to back by a read.
  initial begin
    a = $urandom(11142);
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    @(posedge ref_clk_in);
    #1 outs();
    chk(rdata_out, 0);
    $display("test reset done");
    repeat (80) begin
      a = adr[$urandom % 7];
      d = $urandom % 256;
      // Software keeps reserved bits of F8F, F91 and F93 at zero and never writes hysteresis code 10.
      if (a == 12'hF8F) d = d & 4;
      if (a == 12'hF91 || a == 12'hF93) d = d & 128;
      if (a == 12'hF92 && (d >> 4 & 3) == 2) d = d ^ 16;
      @(posedge ref_clk_in);
      addr_in <= 12'(a);
      wdata_in <= 8'(d);
      {wr_in, cmp0_raw_in, cmp1_raw_in} <= {1'h1, 2'($urandom)};
      @(posedge ref_clk_in);
      {wr_in, rd_in} <= 2'h1;
      @(posedge ref_clk_in);
      rd_in <= 1'h0;
      case (a)
        12'hF8F: win = d >> 2 & 1;
        12'hF90: {pref, p0} = {d >> 3 & 1, d & 3};
        12'hF91: i0 = d >> 7;
        12'hF92: ctl = d;
        12'hF93: i1 = d >> 7;
      endcase
      #1 outs();
      d = a == 12'hF92 ? ctl : a == 12'hF91 ? i0 << 7 : a == 12'hF93 ? i1 << 7 : 0;
      d = a == 12'hF8F ? win * 4 + s : a == 12'hF90 ? pref * 8 + p0 : a == 12'hF94 ? r0 * 2 + r1 : d;
      chk(rdata_out, d);
    end
    $display("test random done");
    conclude();
  end
  // Cuts a hang short far beyond the expected run.
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule // ccr_regs_tb_top
